// File: src/mii_pkg.sv
// shared constants, types and code table for both ends of the mii port
package mii_pkg;

   // clock rates in kHz; dividers derive their half-period counts from them
   localparam int unsigned SYS_KHZ    = 100000;
   localparam int unsigned FAST_KHZ   = 25000;
   localparam int unsigned SERIAL_KHZ = 10000;
   localparam int unsigned SLOW_KHZ   = 2500;
   localparam int unsigned MDC_KHZ    = 2500;
   localparam int unsigned DIV_W      = 6;

   localparam logic [DIV_W-1:0] HALF_FAST   = DIV_W'(SYS_KHZ / (2 * FAST_KHZ));
   localparam logic [DIV_W-1:0] HALF_SERIAL =
      DIV_W'(SYS_KHZ / (2 * SERIAL_KHZ));
   localparam logic [DIV_W-1:0] HALF_SLOW   = DIV_W'(SYS_KHZ / (2 * SLOW_KHZ));
   // a ceiling frequency, so the half period rounds up
   localparam logic [DIV_W-1:0] HALF_MDC    =
      DIV_W'((SYS_KHZ + 2 * MDC_KHZ - 1) / (2 * MDC_KHZ));

   localparam logic [4:0] HALT_CODE = 5'h04;

   // management frame layout, bit indices counted from the start bits
   localparam logic [1:0] MG_START    = 2'h1;
   localparam logic [1:0] MG_OP_READ  = 2'h2;
   localparam logic [1:0] MG_OP_WRITE = 2'h1;
   localparam logic [1:0] MG_TA       = 2'h2;
   localparam logic [4:0] MG_HDR_END  = 5'h0D;
   localparam logic [4:0] MG_TA_LOW   = 5'h0E;
   localparam logic [4:0] MG_TA_BIT   = 5'h0F;
   localparam logic [4:0] MG_DATA_BIT = 5'h10;
   localparam logic [4:0] MG_LAST     = 5'h1F;
   localparam logic [4:0] MG_CTRL_REG = 5'h00;
   localparam int unsigned ISO_CTRL_BIT = 10;

   // controller registers, byte offsets on apb
   localparam logic [7:0] REG_TXDATA   = 8'h00;
   localparam logic [7:0] REG_RXDATA   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_MGMT     = 8'h10;
   localparam logic [7:0] REG_STRAP    = 8'h14;

   localparam int unsigned IRQ_RX   = 0;
   localparam int unsigned IRQ_PHY  = 1;
   localparam int unsigned IRQ_MGMT = 2;
   localparam int unsigned MG_RD_BIT   = 26;
   localparam int unsigned MG_BUSY_BIT = 16;
   localparam int unsigned STRAP_ISO   = 0;
   localparam int unsigned STRAP_SCRAM = 1;
   localparam int unsigned STRAP_ADDR  = 2;
   localparam logic [6:0] STRAP_RST    = 7'h02;

   typedef enum logic {ST_STRAP = 1'b0, ST_RUN = 1'b1} phy_state_t;

   function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
      logic [4:0] c;
      case (n)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         default: c = 5'h1D;
      endcase
      return c;
   endfunction : enc_4b5b

endpackage : mii_pkg

// File: src/mii_if.sv
// mii pins between transceiver and mac, with pull and bus resolution
`timescale 1ns/1ps
`default_nettype none
interface mii_if;
   logic       tx_clk_o, tx_clk_oe, tx_clk;
   logic       tx_en, tx_er;
   logic [3:0] tx_d;
   logic       rx_clk_o, rx_clk_oe, rx_clk;
   logic [3:0] rx_d_o;
   logic       rx_d_oe;
   logic [3:0] rx_d;
   logic       crs_o, crs_oe, crs;
   logic       mdc;
   logic       mdio_m_o, mdio_m_oe, mdio_p_o, mdio_p_oe, mdio;
   logic       irq_n_oe, irq_n;
   // strap resistors, modelled as levels set by the mac end
   logic       pull_iso, pull_scram;
   logic [4:0] pull_addr;

   assign tx_clk = tx_clk_oe ? tx_clk_o : pull_iso;
   assign rx_clk = rx_clk_oe ? rx_clk_o : pull_scram;
   assign rx_d   = rx_d_oe ? rx_d_o : pull_addr[3:0];
   assign crs    = crs_oe ? crs_o : pull_addr[4];
   assign mdio   = mdio_m_oe ? mdio_m_o : (mdio_p_oe ? mdio_p_o : 1'b1);
   assign irq_n  = irq_n_oe ? 1'b0 : 1'b1;

   modport phy (
      output tx_clk_o, tx_clk_oe, rx_clk_o, rx_clk_oe, rx_d_o, rx_d_oe,
      output crs_o, crs_oe, mdio_p_o, mdio_p_oe, irq_n_oe,
      input  tx_clk, rx_clk, rx_d, crs, tx_en, tx_er, tx_d, mdc, mdio
   );
   modport mac (
      output tx_en, tx_er, tx_d, mdc, mdio_m_o, mdio_m_oe,
      output pull_iso, pull_scram, pull_addr,
      input  tx_clk, rx_clk, rx_d, crs, mdio, irq_n
   );
endinterface : mii_if
`default_nettype wire

// File: src/mii_clk_div.sv
// clock divider giving a pin-level clock plus edge enables
`timescale 1ns/1ps
`default_nettype none
module mii_clk_div #(
   parameter int unsigned W = 6
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_half,
   output logic              o_level,
   output logic              o_rise,
   output logic              o_fall
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         level;
      logic         rise;
      logic         fall;
   } div_reg_t;

   div_reg_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
      if (!i_run) begin
         next_s.cnt = '0;
         next_s.level = 1'b0;
         next_s.fall = s.level;
      end else if (s.cnt + W'(1) >= i_half) begin
         next_s.cnt = '0;
         next_s.level = !s.level;
         next_s.rise = !s.level;
         next_s.fall = s.level;
      end else begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_level = s.level;
   assign o_rise  = s.rise;
   assign o_fall  = s.fall;
endmodule : mii_clk_div
`default_nettype wire

// File: src/phy_mii_end.sv
// transceiver end of the mii port: clocks, data paths, straps, management
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - 100M with error flag sends HALT
// - 10M ignores transmit error input
// - coder bypass: error bit is fifth bit
// - serial mode uses transmit bit 0 only
// - mac holds enable exactly over valid data
// - transmit clock 25, 2.5 or 10 MHz
// - transmit clock strap sets electrical_detach_strap bit
// - management data line driven per phase
// - receive nibble, serial uses bit 0
// - receive data pins strap address low
// - carrier sense pin straps address msb
// - open-drain interrupt low on status change
// - receive clock 25, 2.5 or 10 MHz
// - receive clock strap: scrambler/serial select
// - half duplex: carrier on rx or tx
// - repeater/full duplex: carrier on rx only
// - straps captured once, then held, except isolation, which a control register write can change
module phy_mii_end
   import mii_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_speed_100,
   input  wire logic       i_full_duplex,
   input  wire logic       i_repeater,
   input  wire logic       i_forced,
   input  wire logic       i_block_coder_bypass,
   input  wire logic       i_rx_active,
   input  wire logic [3:0] i_rx_nibble,
   input  wire logic       i_status_change,
   mii_if.phy              bus,
   output logic [4:0]      o_tx_code,
   output logic            o_tx_code_valid,
   output logic            o_rx_take,
   output logic            o_electrical_detach_strap,
   output logic            o_scrambler_bypass,
   output logic            o_seven_wire_serial_mode,
   output logic [4:0]      o_mgmt_station_addr
);

   typedef struct packed {
      phy_state_t  st;
      logic        iso;
      logic        scram;
      logic [4:0]  addr;
      logic        drive;
      logic        serial;
      logic        scr_bypass;
      logic [4:0]  tx_code;
      logic        tx_vld;
      logic [3:0]  rxd;
      logic        rx_take;
      logic        crs;
      logic        irq_low;
      logic        mdc_q;
      logic [4:0]  mcnt;
      logic [15:0] msh;
      logic [15:0] mout;
      logic [4:0]  mreg;
      logic        mrd;
      logic        mwr;
      logic        mdio_o;
      logic        mdio_oe;
   } phy_reg_t;

   phy_reg_t s, next_s;

   logic [DIV_W-1:0] half;
   logic             tx_rise;
   logic             tx_level;
   logic             rx_fall;
   logic             rx_level;
   logic             mdc_rise;
   logic             mdc_fall;
   logic [15:0]      wr_word;

   // both clocks follow the same nominal divider; receive is not recovered
   always_comb begin
      if (s.serial) begin
         half = HALF_SERIAL;
      end else if (i_speed_100) begin
         half = HALF_FAST;
      end else begin
         half = HALF_SLOW;
      end
   end

   mii_clk_div #(.W(DIV_W)) tx_div (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_run     (s.drive),
      .i_half    (half),
      .o_level   (tx_level),
      .o_rise    (tx_rise),
      .o_fall    ()
   );

   mii_clk_div #(.W(DIV_W)) rx_div (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_run     (s.drive),
      .i_half    (half),
      .o_level   (rx_level),
      .o_rise    (),
      .o_fall    (rx_fall)
   );

   assign mdc_rise = bus.mdc && !s.mdc_q;
   assign mdc_fall = !bus.mdc && s.mdc_q;
   assign wr_word  = {s.msh[14:0], bus.mdio};

   always_comb begin
      next_s = s;
      next_s.tx_vld = 1'b0;
      next_s.rx_take = 1'b0;
      next_s.mdc_q = bus.mdc;

      // straps are read once, on the first edge after reset release
      if (s.st == ST_STRAP) begin
         next_s.iso = bus.tx_clk;
         next_s.scram = bus.rx_clk;
         next_s.addr = {bus.crs, bus.rx_d};
         next_s.st = ST_RUN;
      end

      // isolation floats the clock, receive data and carrier outputs; mdio and the interrupt stay live
      next_s.drive = (next_s.st == ST_RUN) && !next_s.iso;
      next_s.serial = i_forced && !i_speed_100 && !next_s.scram;
      next_s.scr_bypass = i_forced && i_speed_100 && !next_s.scram;

      if (tx_rise) begin
         next_s.tx_vld = bus.tx_en;
         if (s.serial) begin
            next_s.tx_code = {4'h0, bus.tx_d[0]};
         end else if (!i_speed_100) begin
            next_s.tx_code = {1'b0, bus.tx_d};
         end else if (i_block_coder_bypass) begin
            next_s.tx_code = {bus.tx_er, bus.tx_d};
         end else if (bus.tx_en && bus.tx_er) begin
            next_s.tx_code = HALT_CODE;
         end else begin
            next_s.tx_code = enc_4b5b(bus.tx_d);
         end
      end

      // receive data changes on the falling clock so the mac sees it settled
      if (rx_fall) begin
         next_s.rxd = s.serial ? {3'h0, i_rx_nibble[0]} : i_rx_nibble;
         next_s.rx_take = 1'b1;
      end

      if (i_full_duplex || i_repeater) begin
         next_s.crs = i_rx_active;
      end else begin
         next_s.crs = i_rx_active || bus.tx_en;
      end

      // management frame: start bits 0,1 then op, address, turnaround, data
      if (mdc_rise) begin
         if (s.mcnt == 5'h00) begin
            next_s.mcnt = bus.mdio ? 5'h00 : 5'h01;
         end else if (s.mcnt == 5'h01) begin
            next_s.mcnt = bus.mdio ? 5'h02 : 5'h01;
         end else begin
            next_s.msh = wr_word;
            next_s.mcnt = s.mcnt + 5'h01;
            if (s.mcnt == MG_HDR_END) begin
               next_s.mreg = wr_word[4:0];
               if (wr_word[9:5] == s.addr) begin
                  next_s.mrd = wr_word[11:10] == MG_OP_READ;
                  next_s.mwr = wr_word[11:10] == MG_OP_WRITE;
               end
               next_s.mout = '0;
               if (wr_word[4:0] == MG_CTRL_REG) begin
                  next_s.mout[ISO_CTRL_BIT] = s.iso;
               end
            end
            if (s.mcnt == MG_LAST) begin
               if (s.mwr && s.mreg == MG_CTRL_REG) begin
                  next_s.iso = wr_word[ISO_CTRL_BIT];
               end
               if (s.mrd) begin
                  next_s.irq_low = 1'b0;
               end
               next_s.mrd = 1'b0;
               next_s.mwr = 1'b0;
               next_s.mdio_oe = 1'b0;
            end
         end
      end else if (mdc_fall && s.mrd) begin
         // first turnaround bit stays released, second is driven low
         if (s.mcnt == MG_TA_BIT) begin
            next_s.mdio_oe = 1'b1;
            next_s.mdio_o = 1'b0;
         end else if (s.mcnt >= MG_DATA_BIT) begin
            next_s.mdio_o = s.mout[15];
            next_s.mout = {s.mout[14:0], 1'b0};
         end
      end

      // a change in the same cycle as a clearing read keeps the line low
      if (i_status_change) begin
         next_s.irq_low = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.tx_clk_o  = tx_level;
   assign bus.tx_clk_oe = s.drive;
   assign bus.rx_clk_o  = rx_level;
   assign bus.rx_clk_oe = s.drive;
   assign bus.rx_d_o    = s.rxd;
   assign bus.rx_d_oe   = s.drive;
   assign bus.crs_o     = s.crs;
   assign bus.crs_oe    = s.drive;
   assign bus.mdio_p_o  = s.mdio_o;
   assign bus.mdio_p_oe = s.mdio_oe;
   assign bus.irq_n_oe  = s.irq_low;

   assign o_tx_code                 = s.tx_code;
   assign o_tx_code_valid           = s.tx_vld;
   assign o_rx_take                 = s.rx_take;
   assign o_electrical_detach_strap = s.iso;
   assign o_scrambler_bypass        = s.scr_bypass;
   assign o_seven_wire_serial_mode  = s.serial;
   assign o_mgmt_station_addr       = s.addr;

endmodule : phy_mii_end
`default_nettype wire

// File: src/mac_mii_end.sv
// controller end of the mii port, steered over apb
`timescale 1ns/1ps
`default_nettype none
module mac_mii_end
   import mii_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_irq,
   mii_if.mac               bus
);
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic [6:0]  strap;
      logic        txq_full;
      logic [4:0]  txq;
      logic        tx_en;
      logic [4:0]  tx_word;
      logic        txclk_q;
      logic        rxclk_q;
      logic [4:0]  rx_word;
      logic        irqn_q;
      logic        mg_busy;
      logic        mg_rd;
      logic [31:0] mg_sh;
      logic [4:0]  mg_cnt;
      logic [15:0] mg_data;
      logic        mdo;
      logic        mdoe;
   } mac_reg_t;

   mac_reg_t s, next_s;
   logic     mdc_rise;
   logic     mdc_fall;
   logic     mdc_level;
   logic     access;
   logic     stall;
   logic [2:0] set;
   logic [2:0] clr;

   mii_clk_div #(.W(DIV_W)) mdc_div (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_run     (s.mg_busy),
      .i_half    (HALF_MDC),
      .o_level   (mdc_level),
      .o_rise    (mdc_rise),
      .o_fall    (mdc_fall)
   );

   assign access = i_psel && i_penable && !s.pready;
   // back-pressure: a write to a full transmit slot or to the management register during a busy frame holds pready low
   assign stall = i_pwrite && ((i_paddr == REG_TXDATA && s.txq_full) ||
                               (i_paddr == REG_MGMT && s.mg_busy));

   always_comb begin
      next_s = s;
      set = '0;
      clr = '0;
      next_s.pready = 1'b0;
      next_s.txclk_q = bus.tx_clk;
      next_s.rxclk_q = bus.rx_clk;
      next_s.irqn_q = bus.irq_n;

      // new nibble only after the transceiver has sampled on this rise
      if (bus.tx_clk && !s.txclk_q) begin
         next_s.tx_en = s.txq_full;
         next_s.tx_word = s.txq_full ? s.txq : 5'h00;
         next_s.txq_full = 1'b0;
      end
      if (bus.rx_clk && !s.rxclk_q && bus.crs) begin
         next_s.rx_word = {bus.crs, bus.rx_d};
         set[IRQ_RX] = 1'b1;
      end
      if (s.irqn_q && !bus.irq_n) begin
         set[IRQ_PHY] = 1'b1;
      end

      if (s.mg_busy && mdc_fall) begin
         next_s.mdo = s.mg_sh[31];
         next_s.mg_sh = {s.mg_sh[30:0], 1'b0};
         next_s.mdoe = !(s.mg_rd && s.mg_cnt >= MG_TA_LOW);
      end else if (s.mg_busy && mdc_rise) begin
         if (s.mg_rd && s.mg_cnt >= MG_DATA_BIT) begin
            next_s.mg_data = {s.mg_data[14:0], bus.mdio};
         end
         next_s.mg_cnt = s.mg_cnt + 5'h01;
         if (s.mg_cnt == MG_LAST) begin
            next_s.mg_busy = 1'b0;
            next_s.mdoe = 1'b0;
            set[IRQ_MGMT] = 1'b1;
         end
      end

      if (access && !stall) begin
         next_s.pready = 1'b1;
         next_s.pslverr = 1'b0;
         next_s.prdata = '0;
         case (i_paddr)
            REG_TXDATA: begin
               next_s.prdata[0] = s.txq_full;
               if (i_pwrite) begin
                  next_s.txq = i_pwdata[4:0];
                  next_s.txq_full = 1'b1;
               end
            end
            REG_RXDATA: next_s.prdata[4:0] = s.rx_word;
            REG_IRQ_STAT: begin
               next_s.prdata[2:0] = s.stat;
               if (i_pwrite) begin
                  clr = i_pwdata[2:0];
               end
            end
            REG_IRQ_MASK: begin
               next_s.prdata[2:0] = s.mask;
               if (i_pwrite) begin
                  next_s.mask = i_pwdata[2:0];
               end
            end
            REG_MGMT: begin
               next_s.prdata[15:0] = s.mg_data;
               next_s.prdata[MG_BUSY_BIT] = s.mg_busy;
               if (i_pwrite) begin
                  next_s.mg_rd = i_pwdata[MG_RD_BIT];
                  next_s.mg_busy = 1'b1;
                  next_s.mg_cnt = '0;
                  next_s.mg_data = '0;
                  next_s.mdo = 1'b0;
                  next_s.mdoe = 1'b1;
                  next_s.mg_sh = {MG_START[0],
                     i_pwdata[MG_RD_BIT] ? MG_OP_READ : MG_OP_WRITE,
                     i_pwdata[25:16], MG_TA, i_pwdata[15:0], 1'b0};
               end
            end
            REG_STRAP: begin
               next_s.prdata[6:0] = s.strap;
               if (i_pwrite) begin
                  next_s.strap = i_pwdata[6:0];
               end
            end
            default: next_s.pslverr = 1'b1;
         endcase
      end

      // a new event wins over a clear in the same cycle
      next_s.stat = (s.stat & ~clr) | set;
      next_s.irq = |(next_s.stat & next_s.mask);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
         s.strap <= STRAP_RST;
         s.txclk_q <= 1'b1;
         s.rxclk_q <= 1'b1;
         s.irqn_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_prdata  = s.prdata;
   assign o_pready  = s.pready;
   assign o_pslverr = s.pslverr;
   assign o_irq     = s.irq;

   assign bus.tx_en     = s.tx_en;
   assign bus.tx_er     = s.tx_word[4];
   assign bus.tx_d      = s.tx_word[3:0];
   assign bus.mdc       = mdc_level;
   assign bus.mdio_m_o  = s.mdo;
   assign bus.mdio_m_oe = s.mdoe;
   assign bus.pull_iso   = s.strap[STRAP_ISO];
   assign bus.pull_scram = s.strap[STRAP_SCRAM];
   assign bus.pull_addr  = s.strap[STRAP_ADDR +: 5];
endmodule : mac_mii_end
`default_nettype wire

// File: dv/mii_port_properties.sv
// concurrent checks on the mii wires joining the two ends
`timescale 1ns/1ps
`default_nettype none
module mii_port_properties (
   input wire logic       i_sys_clk,
   input wire logic       i_rst_b,
   input wire logic       tx_clk,
   input wire logic       tx_clk_oe,
   input wire logic       rx_clk,
   input wire logic [3:0] rx_d,
   input wire logic       rx_d_oe,
   input wire logic       crs_oe,
   input wire logic       tx_en,
   input wire logic       mdc,
   input wire logic       mdio_m_oe,
   input wire logic       mdio_p_oe,
   input wire logic       mdio_p_o
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   // first edge after release is the capture edge, pins must still float
   chk_strap_pins_free: assert property (
      $rose(i_rst_b) |-> !tx_clk_oe && !rx_d_oe && !crs_oe)
      else $error("strap pin driven before capture");
   chk_mdio_one_driver: assert property (
      !(mdio_m_oe && mdio_p_oe))
      else $error("both ends drive mdio");
   chk_turnaround_low: assert property (
      $rose(mdio_p_oe) |-> !mdio_p_o)
      else $error("turnaround bit not driven low");
   // half periods are 2, 5 or 20 cycles; a mode switch may stretch one
   chk_tx_clk_rate: assert property (
      $rose(tx_clk) |=> tx_clk ##[1:20] !tx_clk)
      else $error("tx clock half period out of range");
   chk_rx_clk_rate: assert property (
      $rose(rx_clk) |=> rx_clk ##[1:20] !rx_clk)
      else $error("rx clock half period out of range");
   chk_rx_data_edge: assert property (
      rx_d_oe && $past(rx_d_oe) && $changed(rx_d) |-> !$past(rx_clk))
      else $error("rx data moved while rx clock high");
   chk_tx_en_edge: assert property (
      $changed(tx_en) |-> $past(tx_clk))
      else $error("tx enable moved outside tx clock high phase");
   chk_mdc_rate: assert property (
      $rose(mdc) |-> mdc [*8])
      else $error("management clock too fast");

   cover property ($rose(mdio_p_oe));
   cover property ($rose(tx_en));
   cover property (rx_d_oe && $changed(rx_d));
endmodule : mii_port_properties
`default_nettype wire

// File: dv/phy_mac_side_mii_port_test.sv
// self-checking bench: apb-steered controller end against transceiver end
`timescale 1ns/1ps
`default_nettype none
module phy_mac_side_mii_port_test;
   import mii_pkg::*;
   logic        i_sys_clk, i_rst_b, mac_rst_b, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, irq, speed, fdx, bypass, rx_act, st_chg;
   logic        iso_s, scram_s, serial_s, tx_vld, rpt, frc;
   logic [3:0]  rx_nib;
   logic [4:0]  tx_code, addr_s, ad, cw, ex, tq;
   logic [64:0] nt;
   logic [64:0] apb_q[$];
   logic [4:0]  tx_q[$];
   int          num_errors, num_checks, seed, i, m;
   // 4b5b data groups, nibble 0 in the low five bits
   localparam logic [79:0] CODES = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17,
      5'h16, 5'h13, 5'h12, 5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14,
      5'h09, 5'h1E};

   mii_if bus ();
   phy_mii_end phy_mii_end_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_speed_100(speed), .i_full_duplex(fdx), .i_repeater(rpt),
      .i_forced(frc), .i_block_coder_bypass(bypass), .i_rx_active(rx_act),
      .i_rx_nibble(rx_nib), .i_status_change(st_chg), .bus(bus.phy),
      .o_tx_code(tx_code), .o_tx_code_valid(tx_vld), .o_rx_take(),
      .o_electrical_detach_strap(iso_s), .o_scrambler_bypass(scram_s),
      .o_seven_wire_serial_mode(serial_s), .o_mgmt_station_addr(addr_s));
   mac_mii_end mac_mii_end_i (.i_sys_clk(i_sys_clk), .i_rst_b(mac_rst_b),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .bus(bus.mac));
   mii_port_properties mii_port_properties_i (.i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b), .tx_clk(bus.tx_clk), .tx_clk_oe(bus.tx_clk_oe),
      .rx_clk(bus.rx_clk), .rx_d(bus.rx_d), .rx_d_oe(bus.rx_d_oe),
      .crs_oe(bus.crs_oe), .tx_en(bus.tx_en), .mdc(bus.mdc),
      .mdio_m_oe(bus.mdio_m_oe), .mdio_p_oe(bus.mdio_p_oe),
      .mdio_p_o(bus.mdio_p_o));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (e !== g) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // note = {error flag, data mask, masked data}; reads only
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [64:0] n);
      @(posedge i_sys_clk);
      if (!w) apb_q.push_back(n);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      do @(posedge i_sys_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic mgmt_wait();
      do apb(1'b0, REG_MGMT, 32'h0, '0); while (rd[MG_BUSY_BIT] !== 1'b0);
   endtask : mgmt_wait

   task automatic strap(input logic iso, input logic scr);
      ad = 5'($random(seed));
      apb(1'b1, REG_STRAP, {25'h0, ad, scr, iso}, '0);
      i_rst_b <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      chk("electrical_detach_strap", {31'h0, iso}, {31'h0, iso_s});
      chk("scr bypass", {31'h0, speed & !scr}, {31'h0, scram_s});
      chk("serial", {31'h0, !speed & !scr}, {31'h0, serial_s});
      chk("address", {27'h0, ad}, {27'h0, addr_s});
   endtask : strap

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      #200000;
      num_errors++;
      finish_test();
   end

   always @(posedge i_sys_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         nt = apb_q.pop_front();
         chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
         chk("prdata", nt[31:0], prdata & nt[63:32]);
      end
      if (tx_vld === 1'b1) begin
         tq = tx_q.pop_front();
         chk("tx code", {27'h0, tq}, {27'h0, tx_code});
         chk("carrier", {31'h0, !(fdx | rpt)}, {31'h0, bus.crs});
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {speed, fdx, rpt, bypass, rx_act, st_chg, rx_nib} = '0;
      frc = 1'b1;
      seed = 52;
      i_rst_b = 1'b0;
      mac_rst_b = 1'b0;
      repeat (5) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      mac_rst_b <= 1'b1;
      apb(1'b0, REG_STRAP, 32'h0, {1'b0, 32'h7F, 25'h0, STRAP_RST});
      apb(1'b0, 8'h20, 32'h0, {1'b1, 32'hFFFFFFFF, 32'h0});
      speed <= 1'b1;
      strap(1'b1, 1'b0);
      // strap only steers the coder when speed is forced
      frc <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk("unforced", 32'h0, {31'h0, scram_s});
      frc <= 1'b1;
      strap(1'b0, 1'b1);
      // repeater, full duplex, 10M nibble, then seven-wire serial
      for (m = 0; m < 4; m++) begin
         speed <= (m < 2);
         bypass <= (m == 1);
         fdx <= (m == 1);
         rpt <= (m == 0);
         if (m == 3) strap(1'b0, 1'b0);
         repeat (50) @(posedge i_sys_clk);
         for (i = 0; i < 4; i++) begin
            cw = 5'($random(seed));
            ex = (m == 3) ? {4'h0, cw[0]} : (m == 2) ? {1'b0, cw[3:0]} :
                 (m == 1) ? cw : cw[4] ? HALT_CODE : CODES[5 * cw[3:0] +: 5];
            tx_q.push_back(ex);
            apb(1'b1, REG_TXDATA, {27'h0, cw}, '0);
         end
         while (tx_q.size() != 0) @(posedge i_sys_clk);
      end
      rx_nib <= 4'($random(seed));
      rx_act <= 1'b1;
      repeat (200) @(posedge i_sys_clk);
      apb(1'b0, REG_RXDATA, 32'h0, {1'b0, 32'h1F, 28'h1, 3'h0, rx_nib[0]});
      rx_act <= 1'b0;
      apb(1'b1, REG_STRAP, 32'h7C, '0);
      chk("held address", {27'h0, ad}, {27'h0, addr_s});
      apb(1'b1, REG_IRQ_MASK, 32'h2, '0);
      apb(1'b1, REG_IRQ_STAT, 32'h7, '0);
      st_chg <= 1'b1;
      @(posedge i_sys_clk);
      st_chg <= 1'b0;
      repeat (10) @(posedge i_sys_clk);
      chk("irq pin", 32'h0, {31'h0, bus.irq_n});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, REG_IRQ_STAT, 32'h0, {1'b0, 32'h2, 32'h2});
      apb(1'b1, REG_IRQ_MASK, 32'h0, '0);
      repeat (2) @(posedge i_sys_clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, REG_MGMT, {6'h0, ad, 5'h0, 16'h0400}, '0);
      mgmt_wait();
      apb(1'b1, REG_MGMT, {5'h0, 1'b1, ad, 21'h0}, '0);
      mgmt_wait();
      apb(1'b0, REG_MGMT, 32'h0, {1'b0, 32'h1FFFF, 32'h0400});
      chk("electrical_detach_strap set", 32'h1, {31'h0, iso_s});
      chk("irq released", 32'h1, {31'h0, bus.irq_n});
      finish_test();
   end
endmodule : phy_mac_side_mii_port_test
`default_nettype wire
